/* ssd_device_end.sv */
// Switch device end: serial port in addressable and daisy-chain modes.
// Assumes the link clock comes from the host and stands still outside frames.
// Summary of operation
// - Power-up starts in addressable mode.
// - Frame: read flag, seven address, eight data.
// - Serial port acts only while select low.
// - Switch register at 0x20, resets 0x00.
// - Daisy output is input delayed eight clocks.
// - Host shares select, clock; chains output-input.
// - Entry only from addressable by 0x2500.
// - Entry frame echoes 0x25 then zeros.
// - Daisy mode kept until power cycle.
// - Select rise loads last eight bits.
// - First eight daisy output bits are zero.
// - Shift register kept across frames.
// - Sample on rising, change on falling edge.
// - Host sends multiples of eight clocks.
// - Odd counts still load last eight bits.
// - Initialisation phase after power-up reset.
// - Host waits ten microseconds before commands.
// - Power-up fault shown in bits 7:6.
// - External drive select stops oscillator, pump.
// - Stopped oscillator: control kept, low power.
`timescale 1ns/1ps
module ssd_device_end
	import ssd_pkg::*;
(
	// Clock, power-on reset and enable
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       ce,
	// Link
	ssd_link_if.dev         link,
	// Pins
	input  wire logic       spi_select,
	input  wire logic       parallel_ctrl_first,
	input  wire logic       parallel_ctrl_second,
	input  wire logic       external_drive_select,
	input  wire logic [1:0] config_fault,
	// Switch drive and status
	output logic            switch_first_on,
	output logic            switch_second_on,
	output logic            osc_enable,
	output logic            pump_enable,
	output logic            low_power,
	output logic            daisy_mode,
	output logic            init_busy
);
	// Link clock domain.
	logic        link_rst;
	logic        fell_q;
	logic [4:0]  cnt_q;
	logic [15:0] rx_q;
	logic [15:0] frame_w;
	logic        daisy_q;
	logic        dc_active_q;
	logic        read_q;
	logic        sdo_q;
	logic        wr_tgl_q;
	logic [7:0]  wr_data_q;
	logic [7:0]  rd_byte;
	logic        last_edge;

	// System clock domain.
	logic [9:0]  s_w;
	logic        s_cs;
	logic        s_dca;
	logic        s_tgl;
	logic        s_sel;
	logic        s_par1;
	logic        s_par2;
	logic        s_ext;
	logic [1:0]  s_flt;
	logic        cs_prev_q;
	logic        tgl_prev_q;
	logic        daisy_out_q;
	logic [10:0] init_q;
	logic        init_busy_q;
	logic        strap_q;
	logic [1:0]  fault_q;
	logic [1:0]  sw_q;
	logic [7:0]  reg_byte;
	logic        sw1_q;
	logic        sw2_q;
	logic        osc_q;
	logic        pump_q;
	logic        lowp_q;
	logic        cs_rise;
	logic        wr_evt;
	logic        daisy_dummy;

	function automatic logic bit_pick(input logic [7:0] b, input logic [4:0] c);
		bit_pick = b[3'h7 - c[2:0]];
	endfunction

	// The link logic is held in reset through initialisation, while its clock stands still.
	assign link_rst = init_busy_q;
	ssd_sync #(.W(8)) u_rd (.clk(link.sclk), .d(reg_byte), .q(rd_byte));

	assign frame_w   = {rx_q[14:0], link.sdi};
	assign last_edge = (cnt_q == CNT_LAST);

	// Edge count of the current frame, cleared while select is high.
	always_ff @(posedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			cnt_q <= 5'h00;
		end else if (cnt_q != CNT_SAT) begin
			cnt_q <= cnt_q + 5'h01;
		end
	end

	// Read decision taken on the eighth rising edge.
	always_ff @(posedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			read_q <= 1'b0;
		end else if (!daisy_q && cnt_q == CNT_ADDR) begin
			read_q <= rx_q[6] && ({rx_q[5:0], link.sdi} == SWITCH_ADDR);
		end
	end

	// Input shift register and mode flag.
	always_ff @(posedge link.sclk or posedge link_rst) begin
		if (link_rst) begin
			rx_q    <= 16'h0000;
			daisy_q <= 1'b0;
		end else if (!link.cs_n) begin
			if (!daisy_q && last_edge && frame_w == ENTRY_CMD) begin
				daisy_q <= 1'b1;
				rx_q    <= 16'h0000;
			end else begin
				rx_q <= frame_w;
			end
		end
	end

	// Daisy load applies from the first frame begun in daisy mode.
	always_ff @(posedge link.sclk or posedge link_rst) begin
		if (link_rst) begin
			dc_active_q <= 1'b0;
		end else if (!link.cs_n && cnt_q == 5'h00) begin
			dc_active_q <= daisy_q;
		end
	end

	// Addressable register write on the sixteenth rising edge.
	always_ff @(posedge link.sclk or posedge link_rst) begin
		if (link_rst) begin
			wr_tgl_q  <= 1'b0;
			wr_data_q <= SWITCH_RESET;
		end else if (!link.cs_n && !daisy_q && last_edge && !frame_w[RW_BIT]
				&& frame_w[14:8] == SWITCH_ADDR) begin
			wr_tgl_q  <= ~wr_tgl_q;
			wr_data_q <= frame_w[7:0];
		end
	end

	always_ff @(negedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			fell_q <= 1'b0;
		end else begin
			fell_q <= 1'b1;
		end
	end

	// Output bit changes on falling edges.
	always_ff @(negedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			sdo_q <= 1'b0;
		end else if (daisy_q) begin
			sdo_q <= rx_q[DAISY_BITS-1];
		end else if (cnt_q < 5'h08) begin
			sdo_q <= bit_pick(ALIGN_BYTE, cnt_q);
		end else if (cnt_q <= CNT_LAST) begin
			sdo_q <= read_q & bit_pick(rd_byte, cnt_q);
		end else begin
			sdo_q <= 1'b0;
		end
	end

	// First bit stands from the select fall, before any falling edge.
	assign link.sdo = fell_q ? sdo_q : !daisy_q ? ALIGN_BYTE[7]
		: (cnt_q == 5'h00) ? rx_q[DAISY_BITS-1] : rx_q[DAISY_BITS];

	// Crossing into the system clock domain.
	ssd_sync #(.W(10)) u_sys (
		.clk (clk),
		.d   ({link.cs_n, dc_active_q, wr_tgl_q, spi_select, parallel_ctrl_first,
			parallel_ctrl_second, external_drive_select, config_fault, daisy_q}),
		.q   (s_w)
	);
	assign {s_cs, s_dca, s_tgl, s_sel, s_par1, s_par2, s_ext, s_flt, daisy_dummy} = s_w;

	assign cs_rise  = s_cs & ~cs_prev_q;
	assign wr_evt   = s_tgl ^ tgl_prev_q;
	assign reg_byte = {fault_q, RSVD_VALUE, sw_q};

	// Edge detectors and daisy status register on synchronised link levels.
	always_ff @(posedge clk) begin
		if (reset) begin
			cs_prev_q   <= 1'b1;
			tgl_prev_q  <= 1'b0;
			daisy_out_q <= 1'b0;
		end else if (ce) begin
			cs_prev_q   <= s_cs;
			tgl_prev_q  <= s_tgl;
			daisy_out_q <= daisy_dummy;
		end
	end

	// Initialisation phase after power-up.
	always_ff @(posedge clk) begin
		if (reset) begin
			init_q      <= INIT_CYCLES;
			init_busy_q <= 1'b1;
		end else if (ce) begin
			if (init_q != 11'h000) begin
				init_q <= init_q - 11'h001;
			end
			init_busy_q <= (init_q > 11'h001);
		end
	end

	// Fault code captured once after reset release.
	always_ff @(posedge clk) begin
		if (reset) begin
			strap_q <= 1'b1;
			fault_q <= 2'h0;
		end else if (ce && strap_q) begin
			strap_q <= 1'b0;
			fault_q <= s_flt;
		end
	end

	// Switch state register.
	always_ff @(posedge clk) begin
		if (reset) begin
			sw_q <= SWITCH_RESET[1:0];
		end else if (ce && s_sel && !init_busy_q) begin
			if (wr_evt) begin
				sw_q <= wr_data_q[1:0];
			end else if (cs_rise && s_dca) begin
				sw_q <= rx_q[1:0];
			end
		end
	end

	// Switch drive and oscillator control.
	always_ff @(posedge clk) begin
		if (reset) begin
			sw1_q  <= 1'b0;
			sw2_q  <= 1'b0;
			osc_q  <= 1'b0;
			pump_q <= 1'b0;
			lowp_q <= 1'b0;
		end else if (ce) begin
			sw1_q  <= s_sel ? sw_q[SW_FIRST_BIT] : s_par1;
			sw2_q  <= s_sel ? sw_q[SW_SECOND_BIT] : s_par2;
			osc_q  <= ~s_ext;
			pump_q <= ~s_ext;
			lowp_q <= s_ext;
		end
	end

	assign switch_first_on  = sw1_q;
	assign switch_second_on = sw2_q;
	assign osc_enable       = osc_q;
	assign pump_enable      = pump_q;
	assign low_power        = lowp_q;
	assign daisy_mode       = daisy_out_q;
	assign init_busy        = init_busy_q;
endmodule // ssd_device_end

/* ssd_pkg.sv */
// Constants shared by both ends of the switch serial control link.
// Assumes a 125 MHz system clock at each end.
package ssd_pkg;
	// System clock rate and serial clock ceiling.
	localparam int CLK_MHZ       = 125;
	localparam int SCLK_MAX_MHZ  = 10;
	localparam int SCLK_HALF_INT = (CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
	localparam logic [2:0] SCLK_HALF  = 3'(SCLK_HALF_INT);
	localparam logic [2:0] SAMPLE_LAG = 3'h3;
	// Initialisation time after power-up, in microseconds and in cycles.
	localparam int INIT_US         = 10;
	localparam int INIT_CYCLES_INT = INIT_US * CLK_MHZ;
	localparam logic [10:0] INIT_CYCLES = 11'(INIT_CYCLES_INT);
	// Frame layout.
	localparam logic [4:0] CNT_ADDR  = 5'h07;
	localparam logic [4:0] CNT_LAST  = 5'h0f;
	localparam logic [4:0] CNT_SAT   = 5'h1f;
	localparam int         RW_BIT    = 15;
	localparam logic [6:0] SWITCH_ADDR  = 7'h20;
	localparam logic [7:0] SWITCH_RESET = 8'h00;
	localparam logic [7:0] ALIGN_BYTE   = 8'h25;
	localparam logic [15:0] ENTRY_CMD   = 16'h2500;
	localparam int         DAISY_BITS   = 8;
	// Switch register fields.
	localparam int SW_FIRST_BIT  = 0;
	localparam int SW_SECOND_BIT = 1;
	localparam int FAULT_LSB     = 6;
	localparam int FAULT_MSB     = 7;
	localparam logic [3:0] RSVD_VALUE = 4'h0;
	// Host command widths.
	localparam int WORD_BITS = 32;
endpackage

/* ssd_link_if.sv */
// Serial link between the host controller and the switch device.
// Assumes the testbench joins the two ends through one instance.
`timescale 1ns/1ps
interface ssd_link_if;
	logic sclk;
	logic cs_n;
	logic sdi;
	logic sdo;
	modport dev (input sclk, input cs_n, input sdi, output sdo);
	modport host (output sclk, output cs_n, output sdi, input sdo);
endinterface : ssd_link_if

/* ssd_sync.sv */
// Two-flop level synchroniser of parameter width.
// Assumes each bit is a level or a word that stands still while read.
`timescale 1ns/1ps
module ssd_sync #(
	parameter int W = 1
) (
	// Destination clock
	input  wire logic         clk,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk) begin
		meta_q <= d;
		q      <= meta_q;
	end
endmodule // ssd_sync

/* ssd_host_end.sv */
// Host controller end: makes the serial clock by a divider and runs frames.
// Assumes start is held from logic on clk until busy rises, and the device end on the link.
`timescale 1ns/1ps
module ssd_host_end
	import ssd_pkg::*;
(
	// Clock, reset and enable
	input  wire logic                 clk,
	input  wire logic                 reset,
	input  wire logic                 ce,
	// Link
	ssd_link_if.host                  link,
	// Command port
	input  wire logic                 start,
	input  wire logic [WORD_BITS-1:0] tx_word,
	input  wire logic [5:0]           bit_count,
	output logic                      ready,
	output logic                      busy,
	output logic                      done,
	output logic      [WORD_BITS-1:0] rx_word
);
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_LOW  = 3'h1,
		S_HIGH = 3'h3,
		S_TAIL = 3'h2,
		S_GAP  = 3'h6
	} ssd_hstate_t;

	ssd_hstate_t          state_q;
	logic [2:0]           tmr_q;
	logic [10:0]          init_q;
	logic                 ready_q;
	logic                 busy_q;
	logic                 done_q;
	logic                 sclk_q;
	logic                 cs_n_q;
	logic                 sdi_q;
	logic [5:0]           cnt_q;
	logic [5:0]           n_q;
	logic [WORD_BITS-1:0] tx_q;
	logic [WORD_BITS-1:0] rx_q;
	logic                 sdo_s;
	logic                 tick;

	ssd_sync #(.W(1)) u_sdo (.clk(clk), .d(link.sdo), .q(sdo_s));

	assign tick      = (tmr_q == 3'h0);
	assign link.sclk = sclk_q;
	assign link.cs_n = cs_n_q;
	assign link.sdi  = sdi_q;
	assign ready     = ready_q;
	assign busy      = busy_q;
	assign done      = done_q;
	assign rx_word   = rx_q;

	// Power-up wait before the first command is accepted.
	always_ff @(posedge clk) begin
		if (reset) begin
			init_q  <= INIT_CYCLES;
			ready_q <= 1'b0;
		end else if (ce) begin
			if (init_q != 11'h000) begin
				init_q <= init_q - 11'h001;
			end
			ready_q <= (init_q == 11'h001) | ready_q;
		end
	end

	// Half-period timer of the serial clock divider.
	always_ff @(posedge clk) begin
		if (reset || (ce && tick)) begin
			tmr_q <= SCLK_HALF - 3'h1;
		end else if (ce) begin
			tmr_q <= tmr_q - 3'h1;
		end
	end

	// Frame sequencer; the serial clock stands low outside frames.
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= S_IDLE;
			sclk_q  <= 1'b0;
			cs_n_q  <= 1'b1;
			sdi_q   <= 1'b0;
			busy_q  <= 1'b0;
			done_q  <= 1'b0;
			cnt_q   <= 6'h00;
			n_q     <= 6'h00;
			tx_q    <= '0;
			rx_q    <= '0;
		end else if (ce) begin
			done_q <= 1'b0;
			unique case (state_q)
				S_IDLE: begin
					sclk_q <= 1'b0;
					if (start && ready_q && tick) begin
						cs_n_q  <= 1'b0;
						sdi_q   <= tx_word[WORD_BITS-1];
						tx_q    <= tx_word;
						n_q     <= bit_count;
						cnt_q   <= 6'h00;
						busy_q  <= 1'b1;
						state_q <= S_LOW;
					end
				end
				S_LOW: begin
					if (tick) begin
						sclk_q  <= 1'b1;
						state_q <= S_HIGH;
					end
				end
				S_HIGH: begin
					if (tmr_q == SCLK_HALF - 3'h1 - SAMPLE_LAG) begin
						rx_q <= {rx_q[WORD_BITS-2:0], sdo_s};
					end
					if (tick) begin
						sclk_q <= 1'b0;
						cnt_q  <= cnt_q + 6'h01;
						tx_q   <= {tx_q[WORD_BITS-2:0], 1'b0};
						sdi_q  <= tx_q[WORD_BITS-2];
						state_q <= (cnt_q + 6'h01 == n_q) ? S_TAIL : S_LOW;
					end
				end
				S_TAIL: begin
					if (tick) begin
						cs_n_q  <= 1'b1;
						state_q <= S_GAP;
					end
				end
				S_GAP: begin
					if (tick) begin
						busy_q  <= 1'b0;
						done_q  <= 1'b1;
						state_q <= S_IDLE;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end
endmodule // ssd_host_end

/* ssd_link_chk.sv */
// Checker for the serial link between the host end and the device end.
// Assumes it sits beside the link interface in the testbench.
`timescale 1ns/1ps
module ssd_link_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic sdo,
	// Device pins and status
	input wire logic spi_select,
	input wire logic daisy_mode,
	input wire logic switch_first_on,
	input wire logic switch_second_on
);
	logic [15:0] in_q;
	logic [7:0]  out_q;
	logic [5:0]  cnt_q;
	logic [3:0]  dz_q;
	logic        rise_q;
	logic [1:0]  sw;
	assign sw = {switch_second_on, switch_first_on};
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	always_ff @(posedge clk) begin
		rise_q <= $rose(sclk) && !cs_n;
		if ($rose(sclk) && !cs_n) begin
			in_q <= {in_q[14:0], sdi};
			out_q <= {out_q[6:0], sdo};
		end
	end
	always_ff @(posedge clk) begin
		if (reset || $fell(cs_n)) begin
			cnt_q <= 6'h00;
		end else if ($rose(sclk) && !cs_n) begin
			cnt_q <= cnt_q + 6'h01;
		end
	end
	always_ff @(posedge clk) begin
		if (reset || !daisy_mode) begin
			dz_q <= 4'h0;
		end else if ($rose(sclk) && !cs_n && dz_q != 4'h9) begin
			dz_q <= dz_q + 4'h1;
		end
	end
	a_sdi_steady_rise: assert property ($rose(sclk) |-> $stable(sdi))
		else $error("sdi moved at a clock rise");
	a_sdo_fall_only: assert property (daisy_mode && $changed(sdo) |-> $fell(sclk) || $changed(cs_n))
		else $error("sdo moved off a clock fall");
	a_sclk_in_frame: assert property (!$past(reset) && $rose(sclk) |-> !cs_n)
		else $error("clock rise outside a frame");
	a_frame_sixteen: assert property ($rose(cs_n) && !daisy_mode |-> cnt_q == 6'h10)
		else $error("addressable frame not sixteen clocks");
	a_align_byte: assert property (rise_q && !daisy_mode && spi_select && cnt_q == 6'h08 |-> out_q == 8'h25)
		else $error("alignment byte wrong");
	a_zero_after_entry: assert property (rise_q && daisy_mode && dz_q < 4'h9 |-> !out_q[0])
		else $error("nonzero bit after entry");
	a_daisy_delay: assert property (rise_q && dz_q == 4'h9 |-> out_q[0] == in_q[8])
		else $error("daisy output not eight clocks late");
	a_entry_sets: assert property (rise_q && !daisy_mode && spi_select && cnt_q == 6'h10
		&& in_q == 16'h2500 |-> ##[1:8] daisy_mode)
		else $error("entry command not taken");
	a_daisy_kept: assert property (daisy_mode |=> daisy_mode)
		else $error("daisy mode left");
	a_write_loads: assert property ($rose(cs_n) && !daisy_mode && spi_select && cnt_q == 6'h10
		&& in_q[15:8] == 8'h20 |-> ##10 sw == in_q[1:0])
		else $error("write not applied");
	a_daisy_loads: assert property ($rose(cs_n) && dz_q == 4'h9 |-> ##10 sw == in_q[1:0])
		else $error("daisy byte not loaded");
	cover property ($rose(cs_n) && dz_q == 4'h9 && cnt_q == 6'h0c);
	cover property (rise_q && in_q == 16'h2500);
	cover property ($rose(cs_n) && in_q[15:8] == 8'ha0);
endmodule // ssd_link_chk

/* test_switch_spi_daisy_chain_ctrl.sv */
// Testbench joining the host end and the device end over one link.
// Assumes both ends share one 125 MHz clock and one power-on reset.
`timescale 1ns/1ps
module test_switch_spi_daisy_chain_ctrl;
	import ssd_pkg::*;
	typedef struct {
		logic [31:0] rx;
		logic [31:0] mask;
		logic [1:0]  sw;
	} ssd_note_t;
	logic                 clk = 1'b0;
	logic                 reset = 1'b1;
	logic                 start = 1'b0;
	logic [WORD_BITS-1:0] tx_word = '0;
	logic [5:0]           bit_count = 6'h10;
	logic                 ready, busy, done;
	logic [WORD_BITS-1:0] rx_word;
	logic                 spi_select = 1'b0;
	logic                 external_drive_select = 1'b0;
	logic                 parallel_ctrl_first, parallel_ctrl_second;
	logic [1:0]           config_fault;
	logic                 switch_first_on, switch_second_on, daisy_mode, init_busy;
	logic                 osc_enable, pump_enable, low_power;
	logic                 dz = 1'b0;
	logic [7:0]           hist = 8'h00;
	logic [7:0]           d;
	int                   failures = 0;
	int                   checks_done = 0;
	int                   k;
	int                   lens[5] = '{16, 8, 12, 16, 24};
	ssd_note_t            notes[$];
	ssd_note_t            mon;
	always #4 clk = ~clk;
	ssd_link_if ssd_link_if_inst ();
	ssd_host_end ssd_host_end_inst (.clk(clk), .reset(reset), .ce(1'b1),
		.link(ssd_link_if_inst.host), .start(start), .tx_word(tx_word),
		.bit_count(bit_count), .ready(ready), .busy(busy), .done(done), .rx_word(rx_word));
	ssd_device_end ssd_device_end_inst (.clk(clk), .reset(reset), .ce(1'b1),
		.link(ssd_link_if_inst.dev), .spi_select(spi_select),
		.parallel_ctrl_first(parallel_ctrl_first), .parallel_ctrl_second(parallel_ctrl_second),
		.external_drive_select(external_drive_select), .config_fault(config_fault),
		.switch_first_on(switch_first_on), .switch_second_on(switch_second_on),
		.osc_enable(osc_enable), .pump_enable(pump_enable), .low_power(low_power),
		.daisy_mode(daisy_mode), .init_busy(init_busy));
	ssd_link_chk ssd_link_chk_inst (.clk(clk), .reset(reset), .sclk(ssd_link_if_inst.sclk),
		.cs_n(ssd_link_if_inst.cs_n), .sdi(ssd_link_if_inst.sdi), .sdo(ssd_link_if_inst.sdo),
		.spi_select(spi_select), .daisy_mode(daisy_mode),
		.switch_first_on(switch_first_on), .switch_second_on(switch_second_on));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Notes the expected result, runs one frame and waits for its end.
	task automatic frame(input logic [31:0] v, input int n, input logic [31:0] erx,
		input logic [1:0] esw);
		ssd_note_t nt;
		int        i;
		nt.rx = erx;
		nt.sw = esw;
		nt.mask = !spi_select ? 32'h0 : (n == 32) ? '1 : ((32'h1 << n) - 32'h1);
		if (dz) begin
			nt.rx = '0;
			for (i = 0; i < n; i++) begin
				nt.rx = {nt.rx[30:0], hist[7]};
				hist = {hist[6:0], v[31-i]};
			end
			nt.sw = hist[1:0];
		end
		notes.push_back(nt);
		@(negedge clk);
		tx_word = v;
		bit_count = 6'(n);
		start = 1'b1;
		for (i = 0; i < 200 && busy !== 1'b1; i++) @(negedge clk);
		start = 1'b0;
		for (i = 0; i < 1000 && done !== 1'b1; i++) @(negedge clk);
		if (i >= 1000) begin
			failures++;
			$display("[ERR] %0t frame did not end", $time);
		end
	endtask
	always @(negedge clk) begin
		if (done === 1'b1) begin
			if (notes.size() == 0) begin
				failures++;
				$display("[ERR] %0t result with no expectation", $time);
			end else begin
				mon = notes.pop_front();
				chk(rx_word & mon.mask, mon.rx);
				chk(32'({switch_second_on, switch_first_on}), 32'(mon.sw));
			end
		end
	end
	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		$display("[ERR] %0t watchdog expired", $time);
		complete_run();
	end
	initial begin
		void'($urandom(32'hc618_2011));
		config_fault = 2'($urandom);
		parallel_ctrl_first = 1'($urandom);
		parallel_ctrl_second = 1'($urandom);
		repeat (6) @(negedge clk);
		reset = 1'b0;
		for (k = 0; k < 2000 && ready !== 1'b1; k++) @(negedge clk);
		repeat (4) @(negedge clk);
		chk(32'(init_busy), 32'h0);
		chk(32'(daisy_mode), 32'h0);
		chk(32'({switch_second_on, switch_first_on}),
			32'({parallel_ctrl_second, parallel_ctrl_first}));
		$display("test power-up done");
		for (k = 0; k < 2; k++) begin
			external_drive_select = k[0];
			repeat (4) @(negedge clk);
			chk(32'({osc_enable, pump_enable, low_power}), 32'({~k[0], ~k[0], k[0]}));
		end
		$display("test drive select done");
		frame(32'h2003_0000, 16, 32'h0, {parallel_ctrl_second, parallel_ctrl_first});
		spi_select = 1'b1;
		frame(32'ha000_0000, 16, {16'h0, 8'h25, config_fault, 6'h00}, 2'h0);
		external_drive_select = 1'b0;
		$display("test parallel done");
		d = 8'($urandom);
		frame({8'h20, d, 16'h0}, 16, 32'h2500, d[1:0]);
		frame({8'h21, ~d, 16'h0}, 16, 32'h2500, d[1:0]);
		frame(32'ha000_0000, 16, {16'h0, 8'h25, config_fault, 4'h0, d[1:0]}, d[1:0]);
		$display("test addressable done");
		frame(32'h2500_0000, 16, 32'h2500, d[1:0]);
		dz = 1'b1;
		chk(32'(daisy_mode), 32'h1);
		$display("test entry done");
		for (k = 0; k < 5; k++) begin
			frame((k == 3) ? 32'h2500_0000 : $urandom, lens[k], 32'h0, 2'h0);
		end
		chk(32'(daisy_mode), 32'h1);
		$display("test daisy done");
		repeat (20) @(negedge clk);
		chk(32'(notes.size()), 32'h0);
		complete_run();
	end
endmodule // test_switch_spi_daisy_chain_ctrl
